// [dv/awd_core_model.sv]
// Purpose: behavioural analog converter core for the control block
// Assumes: a start pulse begins one conversion of fixed length
// Notes: result lines show the inverse of the value outside the done cycle
module awd_core_model #(
	parameter int LAT = 8
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// control from the block
	input wire logic i_enable,
	input wire logic i_start,
	// value to convert
	input wire logic [9:0] i_value,
	// answer to the block
	output logic o_done,
	output logic [9:0] o_result
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt;
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cnt <= 0;
			o_done <= 1'b0;
			o_result <= 10'h000;
		end else begin
			o_done <= 1'b0;
			o_result <= ~i_value;
			if (!i_enable) begin
				cnt <= 0;
			end else if (i_start) begin
				cnt <= LAT;
			end else if (cnt != 0) begin
				cnt <= cnt - 1;
				if (cnt == 1) begin
					o_done <= 1'b1;
					o_result <= i_value;
				end
			end
		end
	end
endmodule

// [dv/awd_top_tb.sv]
// Purpose: self-checking bench for converter control and window detect
// Assumes: core model answers 8 cycles after a start
// Notes: register access through the plain strobe port
module awd_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import awd_pkg::*;
	logic clk, resetn, wr, rd, strobe, core_done, core_en, core_track, core_start, irq;
	logic [3:0] tmr;
	logic [7:0] addr, wdata, rdata, d;
	logic [9:0] core_result, core_value;
	logic [5:0] one;
	int n_fail, n_checks, cyc, n;
	logic [15:0] gt[8] = '{16'h0040, 16'h0040, 16'h0040, 16'h0080, 16'h0080, 16'h0080,
		16'h0200, 16'h0200};
	logic [15:0] lt[8] = '{16'h0080, 16'h0080, 16'h0080, 16'h0040, 16'h0040, 16'h0040,
		16'h03FF, 16'h03FF};
	logic [9:0] val[8] = '{10'h060, 10'h040, 10'h080, 10'h090, 10'h060, 10'h030,
		10'h3FE, 10'h1FF};
	logic mt[8] = '{1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0};

	awd_top dut_u (.i_clk(clk), .i_resetn(resetn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
		.i_rd(rd), .o_rdata(rdata), .i_tmr0_ovf(tmr[0]), .i_tmr1_ovf(tmr[1]),
		.i_tmr2_ovf(tmr[2]), .i_tmr3_ovf(tmr[3]), .i_ext_strobe(strobe),
		.i_core_done(core_done), .i_core_result(core_result), .o_core_enable(core_en),
		.o_core_track(core_track), .o_core_start(core_start), .o_irq(irq));
	awd_core_model #(.LAT(8)) core_u (.i_clk(clk), .i_resetn(resetn), .i_enable(core_en),
		.i_start(core_start), .i_value(core_value), .o_done(core_done), .o_result(core_result));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wrr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
		chk(nm, d, exp);
	endtask

	// cycles from the go edge to the start pulse, 30 means none
	task automatic wait_start;
		n = 1;
		#1;
		while (core_start !== 1'b1 && n < 30) begin
			@(posedge clk);
			#1 n++;
		end
	endtask

	// mask bit = source code: 1 tmr0, 2 tmr2, 3 tmr1, 4 strobe, 5 tmr3
	task automatic pulse(input logic [5:0] m);
		@(posedge clk);
		tmr <= {m[5], m[2], m[3], m[1]};
		strobe <= m[4];
		@(posedge clk);
		tmr <= 4'h0;
		strobe <= 1'b0;
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			report_and_stop();
		end
	end

	initial begin
		resetn = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		tmr = 4'h0;
		strobe = 1'b0;
		core_value = 10'h000;
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		rchk("gt_low", OFS_GT_LOW, 8'hFF);
		rchk("gt_high", OFS_GT_HIGH, 8'hFF);
		rchk("lt_low", OFS_LT_LOW, 8'h00);
		rchk("lt_high", OFS_LT_HIGH, 8'h00);
		rchk("control", OFS_CONTROL, 8'h00);
		rchk("unmapped", 8'h00, 8'h00);
		for (int i = 0; i < 4; i++)
			wrr(8'(8'hC3 + i), 8'(8'h5A + i));
		for (int i = 0; i < 4; i++)
			rchk("limit_rw", 8'(8'hC3 + i), 8'(8'h5A + i));
		// disabled: busy write must not start
		wrr(OFS_CONTROL, 8'h10);
		wait_start();
		chk("off_start", n, 30);
		chk("off_core", core_en, 1'h0);
		chk("off_track", core_track, 1'h0);
		// enabled, busy written 0
		wrr(OFS_CONTROL, 8'h80);
		wait_start();
		chk("zero_busy", n, 30);
		chk("on_core", core_en, 1'h1);
		wrr(OFS_IRQ_ENABLE, 8'h00);
		for (int k = 0; k < 8; k++) begin
			wrr(OFS_GT_HIGH, gt[k][15:8]);
			wrr(OFS_GT_LOW, gt[k][7:0]);
			wrr(OFS_LT_HIGH, lt[k][15:8]);
			wrr(OFS_LT_LOW, lt[k][7:0]);
			wrr(OFS_CONTROL, 8'h80);
			wrr(OFS_IRQ_CLEAR, 8'h03);
			core_value <= val[k];
			wrr(OFS_CONTROL, 8'h90);
			wait_start();
			chk("soft_start", n, 1);
			chk("conv_track", core_track, 1'h0);
			rchk("busy", OFS_CONTROL, 8'h90);
			repeat (12) @(posedge clk);
			rchk("done_ctl", OFS_CONTROL, {4'hA, mt[k], 3'h0});
			rchk("status", OFS_IRQ_STATUS, {6'h00, mt[k], 1'h1});
			rchk("res_low", OFS_RESULT_LOW, val[k][7:0]);
			rchk("res_high", OFS_RESULT_HIGH, {6'h00, val[k][9:8]});
			chk("masked_irq", irq, 1'h0);
			chk("idle_track", core_track, 1'h1);
		end
		// delayed tracking
		wrr(OFS_CONTROL, 8'hC0);
		wrr(OFS_CONTROL, 8'hD0);
		wait_start();
		chk("delay_start", n, 13);
		chk("delay_track", core_track, 1'h0);
		repeat (12) @(posedge clk);
		wrr(OFS_CONTROL, 8'hC1);
		pulse(6'h02);
		wait_start();
		chk("delay_hw", n, 13);
		repeat (12) @(posedge clk);
		wrr(OFS_IRQ_CLEAR, 8'h03);
		wrr(OFS_IRQ_ENABLE, 8'h01);
		rchk("irq_en", OFS_IRQ_ENABLE, 8'h01);
		for (int s = 1; s < 8; s++) begin
			one = 6'(1 << s);
			wrr(OFS_CONTROL, 8'(8'h80 | s));
			pulse(6'h3E & ~one);
			wait_start();
			chk("wrong_src", n, 30);
			if (s < 6) begin
				pulse(one);
				wait_start();
				chk("src_start", n, 1);
				repeat (12) @(posedge clk);
				#1 chk("irq_set", irq, 1'h1);
				wrr(OFS_IRQ_CLEAR, 8'h01);
				@(posedge clk);
				#1 chk("irq_clr", irq, 1'h0);
			end
		end
		report_and_stop();
	end
endmodule

// [src/awd_pkg.sv]
// Purpose: constants and helpers for converter control and window detect
// Assumes: byte-wide register port, 10 MHz system clock
// Notes: offsets are byte addresses on the plain register port
// Functional notes
// - enable clear holds converter shut down
// - enable set keeps converter ready for starts
// - normal track starts conversion immediately
// - delayed track adds three SAR clocks
// - source 000 starts on busy write one
// - sources 001/010/011 use timers 0/2/1
// - source 100 uses strobe rising edge
// - source 101 uses timer 3 overflow
// - window compare raises flag on condition
// - limits are two 16-bit byte pairs
// - limit order selects inside or outside
// - window flag readable in control register
// - greater high byte, read/write, resets ones
// - greater low byte, read/write, resets ones
// - less bytes read/write, reset to zero
// - results compared as unsigned 10-bit values
package awd_pkg;
	localparam logic [7:0] OFS_GT_LOW = 8'hC3;
	localparam logic [7:0] OFS_GT_HIGH = 8'hC4;
	localparam logic [7:0] OFS_LT_LOW = 8'hC5;
	localparam logic [7:0] OFS_LT_HIGH = 8'hC6;
	localparam logic [7:0] OFS_CONTROL = 8'hE8;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'hF0;
	localparam logic [7:0] OFS_IRQ_CLEAR = 8'hF1;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'hF2;
	localparam logic [7:0] OFS_RESULT_LOW = 8'hF3;
	localparam logic [7:0] OFS_RESULT_HIGH = 8'hF4;
	localparam logic [7:0] RST_GT_BYTE = 8'hFF;
	localparam logic [7:0] RST_LT_BYTE = 8'h00;
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam int BIT_ENABLE = 7;
	localparam int BIT_TRACK = 6;
	localparam int BIT_DONE = 5;
	localparam int BIT_BUSY = 4;
	localparam int BIT_WINDOW = 3;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_WINDOW = 1;
	localparam logic [2:0] SRC_SOFT = 3'h0;
	localparam logic [2:0] SRC_TMR0 = 3'h1;
	localparam logic [2:0] SRC_TMR2 = 3'h2;
	localparam logic [2:0] SRC_TMR1 = 3'h3;
	localparam logic [2:0] SRC_STROBE = 3'h4;
	localparam logic [2:0] SRC_TMR3 = 3'h5;
	localparam int CLK_PERIOD_NS = 100;
	localparam int SAR_PERIOD_NS = 400;
	localparam int SAR_DIV = (SAR_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0] SAR_DIV_LAST = 2'(SAR_DIV - 1);
	localparam logic [1:0] DELAY_SAR_LAST = 2'h2;
	typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_CONVERT} awd_state_t;
	function automatic logic [15:0] awd_word(input logic [7:0] hi, input logic [7:0] lo);
		return {hi, lo};
	endfunction
endpackage

// [src/awd_start_sel.sv]
// Purpose: selects the start-of-conversion source
// Assumes: timer overflows are one-cycle pulses
// Notes: software start is handled by the caller
module awd_start_sel (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// source select
	input wire logic [2:0] i_sel,
	// start sources
	input wire logic i_tmr0_ovf,
	input wire logic i_tmr1_ovf,
	input wire logic i_tmr2_ovf,
	input wire logic i_tmr3_ovf,
	input wire logic i_strobe,
	// hardware start request
	output logic o_go
);
	import awd_pkg::*;
	logic strobe_prev;
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			strobe_prev <= 1'b0;
		end else begin
			strobe_prev <= i_strobe;
		end
	end
	always_comb begin
		unique case (i_sel)
			SRC_TMR0: o_go = i_tmr0_ovf;
			SRC_TMR2: o_go = i_tmr2_ovf;
			SRC_TMR1: o_go = i_tmr1_ovf;
			SRC_STROBE: o_go = i_strobe && !strobe_prev;
			SRC_TMR3: o_go = i_tmr3_ovf;
			default: o_go = 1'b0;
		endcase
	end
endmodule

// [src/awd_top.sv]
// Purpose: converter control with window detector and register port
// Assumes: analog core converts while o_core_start has begun it
// Notes: read data appear one cycle after the read strobe
//
// Design decision made here: the plain strobed port.
module awd_top (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// register port
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	// start sources
	input wire logic i_tmr0_ovf,
	input wire logic i_tmr1_ovf,
	input wire logic i_tmr2_ovf,
	input wire logic i_tmr3_ovf,
	input wire logic i_ext_strobe,
	// analog core
	input wire logic i_core_done,
	input wire logic [9:0] i_core_result,
	output logic o_core_enable,
	output logic o_core_track,
	output logic o_core_start,
	// interrupt
	output logic o_irq
);
	import awd_pkg::*;

	awd_state_t state;
	awd_state_t next_state;
	logic enable;
	logic track_mode;
	logic [2:0] source;
	logic done_flag;
	logic window_flag;
	logic [7:0] gt_high;
	logic [7:0] gt_low;
	logic [7:0] lt_high;
	logic [7:0] lt_low;
	logic [9:0] result;
	logic [1:0] irq_status;
	logic [1:0] irq_enable;
	logic [1:0] sar_div;
	logic [1:0] sar_count;
	logic sar_tick;
	logic hw_go;
	logic soft_go;
	logic go;
	logic match;
	logic done_event;
	logic wr_control;
	logic launch;
	logic idle_ready;

	assign wr_control = i_wr && (i_addr == OFS_CONTROL);
	assign soft_go = wr_control && i_wdata[BIT_BUSY] && (source == SRC_SOFT);
	assign go = enable && (soft_go || hw_go);
	assign done_event = (state == ST_CONVERT) && i_core_done;
	assign sar_tick = (sar_div == SAR_DIV_LAST);
	assign launch = (next_state == ST_CONVERT) && (state != ST_CONVERT);
	assign idle_ready = enable && (state == ST_IDLE) && !wr_control;

	awd_start_sel u_start_sel (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_sel(source),
		.i_tmr0_ovf(i_tmr0_ovf),
		.i_tmr1_ovf(i_tmr1_ovf),
		.i_tmr2_ovf(i_tmr2_ovf),
		.i_tmr3_ovf(i_tmr3_ovf),
		.i_strobe(i_ext_strobe),
		.o_go(hw_go)
	);

	awd_window u_window (
		.i_result(i_core_result),
		.i_gt_word(awd_word(gt_high, gt_low)),
		.i_lt_word(awd_word(lt_high, lt_low)),
		.o_match(match)
	);

	// sequencing of tracking and conversion
	always_comb begin
		next_state = state;
		if (!enable) begin
			next_state = ST_IDLE;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (go) begin
						next_state = track_mode ? ST_DELAY : ST_CONVERT;
					end
				end
				ST_DELAY: begin
					if (sar_tick && (sar_count == DELAY_SAR_LAST)) begin
						next_state = ST_CONVERT;
					end
				end
				ST_CONVERT: begin
					if (i_core_done) begin
						next_state = ST_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// SAR clock divider restarts with each delayed track
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			sar_div <= 2'h0;
			sar_count <= 2'h0;
		end else if (state != ST_DELAY) begin
			sar_div <= 2'h0;
			sar_count <= 2'h0;
		end else if (sar_tick) begin
			sar_div <= 2'h0;
			sar_count <= sar_count + 2'h1;
		end else begin
			sar_div <= sar_div + 2'h1;
		end
	end

	// core control outputs
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_core_enable <= 1'b0;
			o_core_track <= 1'b0;
			o_core_start <= 1'b0;
		end else begin
			o_core_enable <= enable;
			o_core_track <= enable && (next_state != ST_CONVERT);
			o_core_start <= enable && launch;
		end
	end

	// control register fields
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			enable <= RST_CONTROL[BIT_ENABLE];
			track_mode <= RST_CONTROL[BIT_TRACK];
			source <= RST_CONTROL[2:0];
		end else if (wr_control) begin
			enable <= i_wdata[BIT_ENABLE];
			track_mode <= i_wdata[BIT_TRACK];
			source <= i_wdata[2:0];
		end
	end

	// sticky flags: a new event beats a clearing write
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			done_flag <= 1'b0;
			window_flag <= 1'b0;
		end else begin
			if (done_event) begin
				done_flag <= 1'b1;
			end else if (wr_control && !i_wdata[BIT_DONE]) begin
				done_flag <= 1'b0;
			end
			if (done_event && match) begin
				window_flag <= 1'b1;
			end else if (wr_control && !i_wdata[BIT_WINDOW]) begin
				window_flag <= 1'b0;
			end
		end
	end

	// result latch
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			result <= 10'h000;
		end else if (done_event) begin
			result <= i_core_result;
		end
	end

	// window limit registers
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			gt_high <= RST_GT_BYTE;
			gt_low <= RST_GT_BYTE;
			lt_high <= RST_LT_BYTE;
			lt_low <= RST_LT_BYTE;
		end else if (i_wr) begin
			if (i_addr == OFS_GT_HIGH) begin
				gt_high <= i_wdata;
			end
			if (i_addr == OFS_GT_LOW) begin
				gt_low <= i_wdata;
			end
			if (i_addr == OFS_LT_HIGH) begin
				lt_high <= i_wdata;
			end
			if (i_addr == OFS_LT_LOW) begin
				lt_low <= i_wdata;
			end
		end
	end

	// interrupt status, enable and output
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			irq_status <= 2'h0;
			irq_enable <= 2'h0;
			o_irq <= 1'b0;
		end else begin
			if (done_event) begin
				irq_status[IRQ_DONE] <= 1'b1;
			end else if (i_wr && (i_addr == OFS_IRQ_CLEAR) && i_wdata[IRQ_DONE]) begin
				irq_status[IRQ_DONE] <= 1'b0;
			end
			if (done_event && match) begin
				irq_status[IRQ_WINDOW] <= 1'b1;
			end else if (i_wr && (i_addr == OFS_IRQ_CLEAR) && i_wdata[IRQ_WINDOW]) begin
				irq_status[IRQ_WINDOW] <= 1'b0;
			end
			if (i_wr && (i_addr == OFS_IRQ_ENABLE)) begin
				irq_enable <= i_wdata[1:0];
			end
			o_irq <= |(irq_status & irq_enable);
		end
	end

	// read data, one cycle after the strobe
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_rdata <= 8'h00;
		end else if (i_rd) begin
			unique case (i_addr)
				OFS_CONTROL: begin
					o_rdata <= {enable, track_mode, done_flag, (state != ST_IDLE),
						window_flag, source};
				end
				OFS_GT_HIGH: o_rdata <= gt_high;
				OFS_GT_LOW: o_rdata <= gt_low;
				OFS_LT_HIGH: o_rdata <= lt_high;
				OFS_LT_LOW: o_rdata <= lt_low;
				OFS_IRQ_STATUS: o_rdata <= {6'h00, irq_status};
				OFS_IRQ_ENABLE: o_rdata <= {6'h00, irq_enable};
				OFS_RESULT_LOW: o_rdata <= result[7:0];
				OFS_RESULT_HIGH: o_rdata <= {6'h00, result[9:8]};
				default: o_rdata <= 8'h00;
			endcase
		end else begin
			o_rdata <= 8'h00;
		end
	end

	// checks

	sequence s_delay_then_start;
		(!o_core_start)[*8] ##4 !o_core_start ##1 o_core_start;
	endsequence

	a_off_no_start: assert property (
		@(posedge i_clk) disable iff (!i_resetn)
		!enable |=> (state == ST_IDLE) && !o_core_start
	) else $error("converter active while disabled");

	a_on_accepts_start: assert property (
		@(posedge i_clk) disable iff (!i_resetn)
		idle_ready && hw_go |=> (state != ST_IDLE)
	) else $error("enabled converter ignored a start");

	a_normal_start: assert property (
		@(posedge i_clk) disable iff (!i_resetn)
		idle_ready && hw_go && !track_mode |=> o_core_start && (state == ST_CONVERT)
	) else $error("normal track did not start at once");

	a_delayed_start: assert property (
		@(posedge i_clk) disable iff (!i_resetn)
		idle_ready && hw_go && track_mode |=> s_delay_then_start
	) else $error("delayed track length wrong");

	a_soft_start: assert property (
		@(posedge i_clk) disable iff (!i_resetn)
		enable && (state == ST_IDLE) && wr_control && i_wdata[BIT_BUSY]
		&& i_wdata[BIT_ENABLE] && (source == SRC_SOFT) |=> (state != ST_IDLE)
	) else $error("busy write did not start");

	a_zero_write: assert property (
		@(posedge i_clk) disable iff (!i_resetn)
		(state == ST_IDLE) && wr_control && !i_wdata[BIT_BUSY] && (source == SRC_SOFT)
		|=> (state == ST_IDLE)
	) else $error("busy write of zero started a conversion");

	a_timer0_start: assert property (
		@(posedge i_clk) disable iff (!i_resetn)
		idle_ready && (source == SRC_TMR0) && i_tmr0_ovf |=> (state != ST_IDLE)
	) else $error("timer 0 overflow ignored");

	a_strobe_edge: assert property (
		@(posedge i_clk) disable iff (!i_resetn)
		idle_ready && (source == SRC_STROBE) && i_ext_strobe && !$past(i_ext_strobe)
		|=> (state != ST_IDLE)
	) else $error("strobe edge ignored");

	a_timer3_start: assert property (
		@(posedge i_clk) disable iff (!i_resetn)
		idle_ready && (source == SRC_TMR3) && i_tmr3_ovf |=> (state != ST_IDLE)
	) else $error("timer 3 overflow ignored");

	a_window_flag: assert property (
		@(posedge i_clk) disable iff (!i_resetn)
		done_event && match |=> window_flag && irq_status[IRQ_WINDOW]
	) else $error("window match not flagged");

	a_done_sticky: assert property (
		@(posedge i_clk) disable iff (!i_resetn)
		done_flag && !wr_control |=> done_flag
	) else $error("done flag lost without a clear");

	a_reserved_source: assert property (
		@(posedge i_clk) disable iff (!i_resetn)
		(state == ST_IDLE) && (source[2:1] == 2'h3) && !wr_control |=> (state == ST_IDLE)
	) else $error("reserved source started a conversion");

	a_off_power: assert property (
		@(posedge i_clk) disable iff (!i_resetn)
		!enable |=> !o_core_enable
	) else $error("core powered while disabled");

	a_track_convert: assert property (
		@(posedge i_clk) disable iff (!i_resetn)
		(state == ST_CONVERT) |-> !o_core_track
	) else $error("core tracking during a conversion");

	a_done_set: assert property (
		@(posedge i_clk) disable iff (!i_resetn)
		done_event |=> done_flag && irq_status[IRQ_DONE]
	) else $error("conversion end not flagged");

	a_busy_read: assert property (
		@(posedge i_clk) disable iff (!i_resetn)
		i_rd && (i_addr == OFS_CONTROL) |=> o_rdata[BIT_BUSY] == ($past(state) != ST_IDLE)
	) else $error("busy bit wrong on read");
endmodule

// [src/awd_window.sv]
// Purpose: window comparison of a result against two limit words
// Assumes: result is unsigned and right aligned
// Notes: purely combinational
module awd_window (
	// result and limits
	input wire logic [9:0] i_result,
	input wire logic [15:0] i_gt_word,
	input wire logic [15:0] i_lt_word,
	// comparison outcome
	output logic o_match
);
	import awd_pkg::*;
	logic [15:0] value;
	logic above;
	logic below;
	assign value = {6'h00, i_result};
	assign above = value > i_gt_word;
	assign below = value < i_lt_word;
	// limit order picks inside or outside
	assign o_match = (i_lt_word > i_gt_word) ? (above && below) : (above || below);
endmodule
